// [src/mcrb_top.sv]
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/10ps
module mcrb_top #(
    parameter int unsigned TB_CYC0 = mcrb_pkg::TB_CYC0,
    parameter int unsigned TB_CYC1 = mcrb_pkg::TB_CYC1,
    parameter int unsigned TB_CYC2 = mcrb_pkg::TB_CYC2,
    parameter int unsigned TB_CYC3 = mcrb_pkg::TB_CYC3,
    parameter int unsigned TONE_HALF1 = mcrb_pkg::TONE_HALF1,
    parameter int unsigned TONE_HALF2 = mcrb_pkg::TONE_HALF2,
    parameter int unsigned TONE_HALF3 = mcrb_pkg::TONE_HALF3
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic cpu_irq_masked,
    input wire logic wait_mode,
    input wire logic halt_mode,
    output logic active_halt_sel,
    output logic cpu_clk_en,
    output mcrb_pkg::mcrb_pins_t pins,
    output logic irq,
    output logic wake_req
);

    mcrb_pkg::mcrb_state_t s_r;
    mcrb_pkg::mcrb_state_t s_nxt;
    logic active_halt;
    logic full_halt;
    logic acc;
    logic tb_evt;
    logic [mcrb_pkg::TB_W-1:0] tb_last;
    logic [mcrb_pkg::TONE_W-1:0] tone_last;
    logic [mcrb_pkg::DIV_W-1:0] div_mask;
    logic [mcrb_pkg::DIV_W-1:0] div_inc;
    logic [31:0] rd_mux;

    ////////////////////////////////////////////////////////////////////////////
    // power mode decode; enable bit is frozen while halted so the split holds
    assign active_halt = halt_mode & s_r.csr.period_irq_enable;
    assign full_halt = halt_mode & ~s_r.csr.period_irq_enable;
    assign active_halt_sel = s_r.csr.period_irq_enable;

    // access completes in the second cycle, when waitrequest drops
    assign acc = (avs_read | avs_write) & s_r.ack;
    assign avs_waitrequest = (avs_read | avs_write) & ~s_r.ack;
    assign avs_readdata = s_r.rdata;

    // period end of the period now running, not the one just written
    always_comb
    begin
        unique case (s_r.code_act)
            2'b00: tb_last = mcrb_pkg::TB_W'(TB_CYC0 - 1);
            2'b01: tb_last = mcrb_pkg::TB_W'(TB_CYC1 - 1);
            2'b10: tb_last = mcrb_pkg::TB_W'(TB_CYC2 - 1);
            2'b11: tb_last = mcrb_pkg::TB_W'(TB_CYC3 - 1);
        endcase
    end

    // tone half-period; code 0 keeps the counter parked
    always_comb
    begin
        unique case (s_r.tone_code)
            2'b00: tone_last = '0;
            2'b01: tone_last = mcrb_pkg::TONE_W'(TONE_HALF1 - 1);
            2'b10: tone_last = mcrb_pkg::TONE_W'(TONE_HALF2 - 1);
            2'b11: tone_last = mcrb_pkg::TONE_W'(TONE_HALF3 - 1);
        endcase
    end

    // prescaler mask: low code+1 bits of the free divider
    always_comb
    begin
        unique case (s_r.csr.cpu_divider_code)
            2'b00: div_mask = 4'h1;
            2'b01: div_mask = 4'h3;
            2'b10: div_mask = 4'h7;
            2'b11: div_mask = 4'hf;
        endcase
    end

    assign div_inc = s_r.div_cnt + 4'h1;
    assign tb_evt = ~full_halt & (s_r.tb_cnt == tb_last);

    // register read mux, unmapped reads as zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (avs_address)
            mcrb_pkg::ADDR_CSR: rd_mux = {24'h00_0000, s_r.csr};
            mcrb_pkg::ADDR_TONE: rd_mux = {30'h0000_0000, s_r.tone_code};
            mcrb_pkg::ADDR_IRQ_ST: rd_mux = {31'h0000_0000, s_r.irq_st};
            mcrb_pkg::ADDR_IRQ_MASK: rd_mux = {31'h0000_0000, s_r.irq_mask};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.ack = (avs_read | avs_write) & ~s_r.ack;
        if (avs_read && !s_r.ack)
        begin
            s_nxt.rdata = rd_mux;
        end

        // divider and clock-out run side by side; stopped with the cpu in halt
        if (!halt_mode)
        begin
            s_nxt.div_cnt = div_inc;
            if (s_r.csr.slow_select)
            begin
                s_nxt.clk_out = div_inc[s_r.csr.cpu_divider_code];
            end
            else
            begin
                // one flop cannot repeat the oscillator, so full rate shows as half
                s_nxt.clk_out = ~s_r.clk_out;
            end
        end

        // time base: runs in wait and active-halt, frozen in full halt
        if (!full_halt)
        begin
            if (tb_evt)
            begin
                s_nxt.tb_cnt = '0;
                s_nxt.code_act = s_r.csr.period_code;
            end
            else
            begin
                s_nxt.tb_cnt = s_r.tb_cnt + 18'h0_0001;
            end
        end

        // tone: runs in active-halt, frozen only in full halt
        if (s_r.tone_code == 2'b00)
        begin
            s_nxt.tone_cnt = '0;
            s_nxt.tone_lvl = 1'b0;
        end
        else if (!full_halt)
        begin
            if (s_r.tone_cnt >= tone_last)
            begin
                s_nxt.tone_cnt = '0;
                s_nxt.tone_lvl = ~s_r.tone_lvl;
            end
            else
            begin
                s_nxt.tone_cnt = s_r.tone_cnt + 13'h0001;
            end
        end

        // software side; registers frozen while halted
        if (acc && !halt_mode)
        begin
            if (avs_read && avs_address == mcrb_pkg::ADDR_CSR)
            begin
                s_nxt.csr.period_elapsed_flag = 1'b0;
            end
            if (avs_write)
            begin
                unique case (avs_address)
                    mcrb_pkg::ADDR_CSR:
                    begin
                        // flag bit is not writable
                        s_nxt.csr.clock_out_select = avs_writedata[mcrb_pkg::CSR_CLKOUT_BIT];
                        s_nxt.csr.cpu_divider_code =
                            avs_writedata[mcrb_pkg::CSR_DIV_LSB +: 2];
                        s_nxt.csr.slow_select = avs_writedata[mcrb_pkg::CSR_SLOW_BIT];
                        s_nxt.csr.period_code = avs_writedata[mcrb_pkg::CSR_PCODE_LSB +: 2];
                        s_nxt.csr.period_irq_enable = avs_writedata[mcrb_pkg::CSR_IRQEN_BIT];
                    end
                    mcrb_pkg::ADDR_TONE: s_nxt.tone_code = avs_writedata[1:0];
                    mcrb_pkg::ADDR_IRQ_ST:
                    begin
                        if (avs_writedata[0])
                        begin
                            s_nxt.irq_st = 1'b0;
                        end
                    end
                    mcrb_pkg::ADDR_IRQ_MASK: s_nxt.irq_mask = avs_writedata[0];
                    default: s_nxt.irq_mask = s_r.irq_mask;
                endcase
            end
        end

        // event set comes last so it wins over a same-cycle clear
        if (tb_evt)
        begin
            s_nxt.csr.period_elapsed_flag = 1'b1;
            s_nxt.irq_st = 1'b1;
        end
    end

    // state register
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_r <= '0;
            s_r.csr <= mcrb_pkg::CSR_RST;
            s_r.tone_code <= mcrb_pkg::TONE_RST[1:0];
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign cpu_clk_en = ~halt_mode &
        (~s_r.csr.slow_select | ((s_r.div_cnt & div_mask) == div_mask));
    assign pins.clock_out_oe = s_r.csr.clock_out_select;
    assign pins.clock_out_port_pin = s_r.csr.clock_out_select & s_r.clk_out & ~active_halt;
    assign pins.tone_oe = (s_r.tone_code != 2'b00);
    assign pins.tone_port_pin = s_r.tone_lvl;
    assign irq = s_r.irq_st & s_r.irq_mask & s_r.csr.period_irq_enable &
        ~cpu_irq_masked;
    // wake ignores the cpu mask; full halt is left alone
    assign wake_req = s_r.irq_st & s_r.irq_mask & s_r.csr.period_irq_enable &
        (wait_mode | active_halt);

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_evt_seen;
        tb_evt ##1 s_r.csr.period_elapsed_flag;
    endsequence

    property p_full_rate;
        !s_r.csr.slow_select && !halt_mode |-> cpu_clk_en;
    endproperty
    a_full_rate: assert property (p_full_rate) else $error("cpu clock not at full rate");

    property p_div16;
        s_r.csr.slow_select && s_r.csr.cpu_divider_code == 2'b11 && cpu_clk_en && !halt_mode
            ##1 (!halt_mode && $stable(s_r.csr))[*8] |-> !cpu_clk_en;
    endproperty
    a_div16: assert property (p_div16) else $error("divide by 16 enable too early");

    // a csr write in the next cycle may change the divide, so only a steady csr counts
    property p_div2;
        s_r.csr.slow_select && s_r.csr.cpu_divider_code == 2'b00 && cpu_clk_en && !halt_mode
            ##1 $stable(s_r.csr) |-> !cpu_clk_en;
    endproperty
    a_div2: assert property (p_div2) else $error("divide by 2 enable twice");

    property p_clkout;
        active_halt || !s_r.csr.clock_out_select |-> !pins.clock_out_port_pin;
    endproperty
    a_clkout: assert property (p_clkout) else $error("clock out wrong");

    property p_clkout_oe;
        pins.clock_out_oe == s_r.csr.clock_out_select;
    endproperty
    a_clkout_oe: assert property (p_clkout_oe) else $error("clock out enable wrong");

    property p_period;
        tb_evt && s_r.code_act == 2'b00 |-> s_r.tb_cnt == 18'(TB_CYC0 - 1);
    endproperty
    a_period: assert property (p_period) else $error("period length wrong");

    property p_restart;
        tb_evt |=> s_r.tb_cnt == 18'h0_0000;
    endproperty
    a_restart: assert property (p_restart) else $error("counter not restarted");

    property p_code_hold;
        !tb_evt |=> $stable(s_r.code_act);
    endproperty
    a_code_hold: assert property (p_code_hold) else $error("period code changed mid period");

    property p_flag;
        tb_evt |-> s_evt_seen;
    endproperty
    a_flag: assert property (p_flag) else $error("flag not set");

    property p_flag_clr;
        acc && avs_read && avs_address == mcrb_pkg::ADDR_CSR && !halt_mode && !tb_evt
            |=> !s_r.csr.period_elapsed_flag;
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared by read");

    property p_irq;
        irq |-> s_r.csr.period_irq_enable && !cpu_irq_masked && s_r.irq_st;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt without enable");

    property p_ah_run;
        active_halt && !tb_evt |=> s_r.tb_cnt == 18'($past(s_r.tb_cnt) + 18'h0_0001);
    endproperty
    a_ah_run: assert property (p_ah_run) else $error("counter stopped in active-halt");

    property p_halt_freeze;
        full_halt |=> $stable(s_r.tb_cnt) && $stable(s_r.csr) && !wake_req;
    endproperty
    a_halt_freeze: assert property (p_halt_freeze) else $error("full halt not frozen");

    property p_tone_off;
        s_r.tone_code == 2'b00 |=> !pins.tone_port_pin;
    endproperty
    a_tone_off: assert property (p_tone_off) else $error("tone pin active while off");

endmodule

// [src/mcrb_pkg.sv]
package mcrb_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register map: index constants, byte address is four times the index
    localparam logic [7:0] IDX_CSR = 8'h2c;
    localparam logic [7:0] IDX_TONE = 8'h2d;
    localparam logic [7:0] IDX_IRQ_ST = 8'h2e;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h2f;
    localparam logic [7:0] ADDR_CSR = {IDX_CSR[5:0], 2'b00};
    localparam logic [7:0] ADDR_TONE = {IDX_TONE[5:0], 2'b00};
    localparam logic [7:0] ADDR_IRQ_ST = {IDX_IRQ_ST[5:0], 2'b00};
    localparam logic [7:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK[5:0], 2'b00};

    // field positions of the control/status register
    localparam int unsigned CSR_CLKOUT_BIT = 7;
    localparam int unsigned CSR_DIV_LSB = 5;
    localparam int unsigned CSR_SLOW_BIT = 4;
    localparam int unsigned CSR_PCODE_LSB = 2;
    localparam int unsigned CSR_IRQEN_BIT = 1;
    localparam int unsigned CSR_FLAG_BIT = 0;

    // values after reset
    localparam logic [7:0] CSR_RST = 8'h00;
    localparam logic [7:0] TONE_RST = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // time-base periods in oscillator cycles
    localparam int unsigned TB_CYC0 = 16000;
    localparam int unsigned TB_CYC1 = 32000;
    localparam int unsigned TB_CYC2 = 80000;
    localparam int unsigned TB_CYC3 = 200000;
    localparam int unsigned TB_W = 18;

    // tone frequencies, referred to an 8 MHz oscillator
    localparam int unsigned TONE_REF_OSC_HZ = 8000000;
    localparam int unsigned TONE_HZ1 = 2000;
    localparam int unsigned TONE_HZ2 = 1000;
    localparam int unsigned TONE_HZ3 = 500;
    localparam int unsigned TONE_HALF1 = TONE_REF_OSC_HZ / (2 * TONE_HZ1);
    localparam int unsigned TONE_HALF2 = TONE_REF_OSC_HZ / (2 * TONE_HZ2);
    localparam int unsigned TONE_HALF3 = TONE_REF_OSC_HZ / (2 * TONE_HZ3);
    localparam int unsigned TONE_W = 13;

    localparam int unsigned DIV_W = 4;

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic clock_out_select;
        logic [1:0] cpu_divider_code;
        logic slow_select;
        logic [1:0] period_code;
        logic period_irq_enable;
        logic period_elapsed_flag;
    } mcrb_csr_t;

    typedef struct packed {
        logic clock_out_port_pin;
        logic clock_out_oe;
        logic tone_port_pin;
        logic tone_oe;
    } mcrb_pins_t;

    typedef struct packed {
        mcrb_csr_t csr;
        logic [1:0] tone_code;
        logic irq_st;
        logic irq_mask;
        logic [DIV_W-1:0] div_cnt;
        logic clk_out;
        logic [TB_W-1:0] tb_cnt;
        logic [1:0] code_act;
        logic [TONE_W-1:0] tone_cnt;
        logic tone_lvl;
        logic ack;
        logic [31:0] rdata;
    } mcrb_state_t;

endpackage

// [verif/mcrb_pin_model.sv]
`timescale 1ns/10ps
// external listener on the clock-out and tone pins
module mcrb_pin_model (
    input wire logic sys_clk,
    input wire mcrb_pkg::mcrb_pins_t pins,
    output int tone_half,
    output int tone_edges,
    output int clk_edges
);
    int cnt = 0;
    logic tone_q = 1'b0;
    logic clk_q = 1'b0;

    // sampled mid-cycle so pin updates at the edge have settled
    always @(negedge sys_clk)
    begin
        cnt <= cnt + 1;
        if (pins.tone_port_pin !== tone_q)
        begin
            tone_half <= cnt;
            tone_edges <= tone_edges + 1;
            cnt <= 1;
        end
        if (pins.clock_out_port_pin === 1'b1 && clk_q === 1'b0)
        begin
            clk_edges <= clk_edges + 1;
        end
        tone_q <= pins.tone_port_pin;
        clk_q <= pins.clock_out_port_pin;
    end
endmodule

// [verif/test_main_clock_rtc_beeper.sv]
`timescale 1ns/10ps
module test_main_clock_rtc_beeper;
    logic sys_clk;
    logic rst_n;
    logic [7:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic cpu_irq_masked;
    logic wait_mode;
    logic halt_mode;
    logic active_halt_sel;
    logic cpu_clk_en;
    mcrb_pkg::mcrb_pins_t pins;
    logic irq;
    logic wake_req;
    int fails = 0;
    int checked = 0;
    int cyc = 0;
    int tone_half;
    int tone_edges;
    int clk_edges;
    int per[4] = '{16, 32, 80, 200};
    int half[4] = '{0, 4, mcrb_pkg::TONE_HALF2, mcrb_pkg::TONE_HALF3};

    // short periods keep the run brief; the slower tones keep their real half periods
    mcrb_top #(.TB_CYC0(16), .TB_CYC1(32), .TB_CYC2(80), .TB_CYC3(200),
        .TONE_HALF1(4)) i_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .cpu_irq_masked(cpu_irq_masked), .wait_mode(wait_mode), .halt_mode(halt_mode),
        .active_halt_sel(active_halt_sel), .cpu_clk_en(cpu_clk_en), .pins(pins),
        .irq(irq), .wake_req(wake_req));
    mcrb_pin_model i_pins (.sys_clk(sys_clk), .pins(pins), .tone_half(tone_half),
        .tone_edges(tone_edges), .clk_edges(clk_edges));

    always @(posedge sys_clk)
        cyc <= cyc + 1;

    ////////////////////////////////////////////////////////////////////////////
    task end_of_test;
        if (fails == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one access; held up to the rising edge that sees waitrequest low, data taken there
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
        int n;
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h000000, d};
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        chk("bus answer", 1'b0, avs_waitrequest);
        if (n >= 50)
            end_of_test;
        r = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        bus(1'b0, a, 8'h00, v);
        chk(what, exp, v);
    endtask

    function automatic logic [7:0] csr(input logic co, input logic [1:0] dv, input logic sl,
        input logic [1:0] pc, input logic ie);
        return {co, dv, sl, pc, ie, 1'b0};
    endfunction

    // waits for a named output to go high, bounded
    task wait_hi(input int which, input int lim, output int t);
        int n;
        n = 0;
        do
        begin
            @(negedge sys_clk);
            n++;
        end
        while ((which == 0 ? irq : wake_req) !== 1'b1 && n < lim);
        t = cyc;
        if (n >= lim)
        begin
            chk("wait for output", 1'b1, 1'b0);
            end_of_test;
        end
    endtask

    task count_en(output int n);
        n = 0;
        repeat (64)
        begin
            @(negedge sys_clk);
            if (cpu_clk_en === 1'b1)
                n++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task t_reset;
        rdchk("csr reset", mcrb_pkg::ADDR_CSR, 32'h00000000);
        rdchk("tone reset", mcrb_pkg::ADDR_TONE, 32'h00000000);
        rdchk("unmapped read", 8'h00, 32'h00000000);
    endtask

    task t_timebase;
        int ta;
        int tb;
        int tc;
        int prev;
        prev = 0;
        wr(mcrb_pkg::ADDR_IRQ_MASK, 8'h01);
        wr(mcrb_pkg::ADDR_CSR, csr(0, 0, 0, 0, 1));
        wr(mcrb_pkg::ADDR_IRQ_ST, 8'h01);
        for (int i = 0; i < 4; i++)
        begin
            wait_hi(0, 500, ta);
            wr(mcrb_pkg::ADDR_IRQ_ST, 8'h01);
            wr(mcrb_pkg::ADDR_CSR, csr(0, 0, 0, i[1:0], 1));
            wait_hi(0, 500, tb);
            wr(mcrb_pkg::ADDR_IRQ_ST, 8'h01);
            wait_hi(0, 500, tc);
            wr(mcrb_pkg::ADDR_IRQ_ST, 8'h01);
            chk("period before switch", per[prev], tb - ta);
            chk("period after switch", per[i], tc - tb);
            prev = i;
        end
        rdchk("flag set", mcrb_pkg::ADDR_CSR, {24'h0, csr(0, 0, 0, 3, 1) | 8'h01});
        rdchk("flag cleared by read", mcrb_pkg::ADDR_CSR, {24'h0, csr(0, 0, 0, 3, 1)});
        @(posedge sys_clk);
        cpu_irq_masked <= 1'b1;
        repeat (205) @(negedge sys_clk);
        chk("irq while cpu masked", 1'b0, irq);
        @(posedge sys_clk);
        cpu_irq_masked <= 1'b0;
        @(negedge sys_clk);
        chk("irq when unmasked", 1'b1, irq);
        wr(mcrb_pkg::ADDR_CSR, csr(0, 0, 0, 0, 0));
        @(negedge sys_clk);
        chk("irq with enable off", 1'b0, irq);
        wr(mcrb_pkg::ADDR_IRQ_ST, 8'h01);
    endtask

    task t_slow;
        int n;
        int e;
        for (int d = 0; d < 4; d++)
        begin
            wr(mcrb_pkg::ADDR_CSR, csr(1, d[1:0], 1, 0, 0));
            count_en(n);
            chk("slow enables", 64 >> (d + 1), n);
        end
        wr(mcrb_pkg::ADDR_CSR, csr(1, 0, 0, 0, 0));
        e = clk_edges;
        count_en(n);
        chk("normal enables", 64, n);
        chk("clock-out running", 1'b1, clk_edges > e);
        chk("clock-out enable", 1'b1, pins.clock_out_oe);
        wr(mcrb_pkg::ADDR_CSR, csr(0, 0, 0, 0, 0));
        @(negedge sys_clk);
        chk("pin free", 1'b0, pins.clock_out_oe);
    endtask

    task t_tone;
        for (int c = 1; c < 4; c++)
        begin
            wr(mcrb_pkg::ADDR_TONE, c[7:0]);
            // two full half periods so the listener measures one clean half
            repeat (2 * half[c] + 10) @(negedge sys_clk);
            chk("tone half period", half[c], tone_half);
            chk("tone enable", 1'b1, pins.tone_oe);
            rdchk("tone readback", mcrb_pkg::ADDR_TONE, c);
        end
        wr(mcrb_pkg::ADDR_TONE, 8'h00);
        // the level register drops one cycle after the code
        repeat (2) @(negedge sys_clk);
        chk("tone off", 2'b00, {pins.tone_oe, pins.tone_port_pin});
    endtask

    // active-halt wakes on the time base, full halt freezes time base, tone and registers
    task t_power;
        int t;
        int e;
        wr(mcrb_pkg::ADDR_TONE, 8'h01);
        wr(mcrb_pkg::ADDR_CSR, csr(1, 0, 0, 0, 1));
        wr(mcrb_pkg::ADDR_IRQ_ST, 8'h01);
        e = clk_edges;
        t = tone_edges;
        @(posedge sys_clk);
        halt_mode <= 1'b1;
        @(negedge sys_clk);
        chk("active-halt chosen", 1'b1, active_halt_sel);
        wait_hi(1, 40, e);
        chk("clock-out stopped", 1'b0, pins.clock_out_port_pin);
        chk("cpu clock stopped", 1'b0, cpu_clk_en);
        repeat (10) @(negedge sys_clk);
        chk("tone in active-halt", 1'b1, tone_edges > t);
        wr(mcrb_pkg::ADDR_TONE, 8'h02);
        @(posedge sys_clk);
        halt_mode <= 1'b0;
        rdchk("frozen in active-halt", mcrb_pkg::ADDR_TONE, 32'h00000001);
        wr(mcrb_pkg::ADDR_IRQ_ST, 8'h01);
        @(posedge sys_clk);
        wait_mode <= 1'b1;
        wait_hi(1, 40, e);
        // second wake comes from a fresh event, so halt below starts before the next event is due
        wr(mcrb_pkg::ADDR_IRQ_ST, 8'h01);
        wait_hi(1, 40, e);
        chk("cpu clock in wait", 1'b1, cpu_clk_en);
        @(posedge sys_clk);
        wait_mode <= 1'b0;
        wr(mcrb_pkg::ADDR_CSR, csr(0, 0, 0, 0, 0));
        wr(mcrb_pkg::ADDR_IRQ_ST, 8'h01);
        @(posedge sys_clk);
        halt_mode <= 1'b1;
        @(negedge sys_clk);
        chk("full halt chosen", 1'b0, active_halt_sel);
        wr(mcrb_pkg::ADDR_TONE, 8'h00);
        t = tone_edges;
        repeat (40) @(negedge sys_clk);
        chk("no wake in halt", 1'b0, wake_req);
        chk("tone frozen in halt", t, tone_edges);
        // reads are still answered in halt; checked before the time base runs again
        rdchk("frozen in halt", mcrb_pkg::ADDR_TONE, 32'h00000001);
        rdchk("no event in halt", mcrb_pkg::ADDR_IRQ_ST, 32'h00000000);
        @(posedge sys_clk);
        halt_mode <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    initial
    begin
        rst_n = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        cpu_irq_masked = 1'b0;
        wait_mode = 1'b0;
        halt_mode = 1'b0;
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset;
        t_timebase;
        t_slow;
        t_tone;
        t_power;
        end_of_test;
    end
endmodule
